/* File: rtl/qhp_device.sv */
// Summary of operation
// RQ1: Strap high strobe style, low direction style
// RQ2: Three address lines pick channel register
// RQ3: Eight-bit data bus, device drives reads only
// RQ4: Read strobe fall drives byte, host samples rise
// RQ5: Write strobe rise stores bus byte
// RQ6: Four active-low selects enable channels
// RQ7: Direction style ignores read strobe, tied high
// RQ8: Direction line high reads, low writes
// RQ9: First select qualifies direction-style accesses
// RQ10: Second, third selects form channel address
// RQ11: Fourth select ignored, tied high
// RQ12: Host asserts one select, holds lines stable
`include "qhp_regs.svh"
module qhp_device
(
    // Host bus
    qhp_bus_if.dev            bus,
    // Clock and reset
    input  wire logic         CLK,
    input  wire logic         RSTN,
    // Register file view
    input  wire logic [1:0]   RD_CHAN,
    input  wire logic [2:0]   RD_ADDR,
    output logic      [7:0]   RD_DATA,
    output logic              WR_PULSE,
    output logic      [1:0]   WR_CHAN,
    output logic      [2:0]   WR_ADDR,
    output logic      [7:0]   WR_DATA
);
    localparam int NREG = `QHP_NUM_CHAN * 8;
    // Two-stage synchronisers on all pins
    logic [17:0] s1_r;
    logic [17:0] s2_r;
    logic [17:0] pins;
    assign pins = {bus.bus_style, bus.reg_addr, bus.data_bus, bus.read_strobe_n, bus.write_strobe_n,
                   bus.chan0_select_n, bus.chan1_select_n, bus.chan2_select_n, bus.chan3_select_n};
    logic       style;
    logic [2:0] addr;
    logic [7:0] din;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] cs_n;
    assign style = s2_r[17];
    assign addr  = s2_r[16:14];
    assign din   = s2_r[13:6];
    assign rd_n  = s2_r[5];
    assign wr_n  = s2_r[4];
    assign cs_n  = s2_r[3:0];
    // Register storage
    logic [7:0] mem_r [NREG];
    logic [7:0] mem_nxt [NREG];
    logic       act_r, act_nxt, rdg_r, rdg_nxt;
    logic [1:0] ch_r, ch_nxt;
    logic [2:0] ad_r, ad_nxt;
    logic [7:0] dq_r, dq_nxt;
    logic       oe_r, oe_nxt;
    logic       wp_r, wp_nxt;
    logic [7:0] rdd_r, rdd_nxt;
    function automatic logic [1:0] chan_of(input logic [3:0] c);
        // Lowest asserted select wins
        if (!c[3])      chan_of = 2'd0;
        else if (!c[2]) chan_of = 2'd1;
        else if (!c[1]) chan_of = 2'd2;
        else            chan_of = 2'd3;
    endfunction : chan_of
    logic       sel;
    logic       want_rd;
    logic       want_wr;
    logic [1:0] ch;
    always_comb
    begin
        if (style) // see RQ1
        begin
            sel     = (cs_n != 4'hf); // see RQ6
            ch      = chan_of(cs_n); // see RQ12
            want_rd = sel && !rd_n; // see RQ4
            want_wr = sel && !wr_n; // see RQ5
        end
        else
        begin
            sel     = !cs_n[3]; // see RQ9
            ch      = {cs_n[1], cs_n[2]}; // see RQ10
            want_rd = sel && wr_n; // see RQ8
            want_wr = sel && !wr_n; // see RQ8
        end
    end
    always_comb
    begin
        act_nxt = act_r;
        rdg_nxt = rdg_r;
        ch_nxt  = ch_r;
        ad_nxt  = ad_r;
        dq_nxt  = dq_r;
        oe_nxt  = 1'b0;
        wp_nxt  = 1'b0;
        for (int i = 0; i < NREG; i++)
        begin
            mem_nxt[i] = mem_r[i];
        end
        rdd_nxt = mem_r[{RD_CHAN, RD_ADDR}];
        if (!act_r)
        begin
            if (want_rd || want_wr)
            begin
                act_nxt = 1'b1;
                rdg_nxt = want_rd;
                ch_nxt  = ch;
                ad_nxt  = addr; // see RQ2
                dq_nxt  = mem_r[{ch, addr}];
                oe_nxt  = want_rd; // see RQ3
            end
        end
        else if (rdg_r)
        begin
            oe_nxt = want_rd;
            if (!want_rd)
            begin
                act_nxt = 1'b0;
            end
        end
        else if (want_wr)
        begin
            dq_nxt = din;
        end
        else
        begin
            act_nxt = 1'b0;
            wp_nxt  = 1'b1;
            mem_nxt[{ch_r, ad_r}] = dq_r; // see RQ5
        end
    end
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s1_r  <= '1;
            s2_r  <= '1;
            act_r <= 1'b0;
            rdg_r <= 1'b0;
            ch_r  <= 2'd0;
            ad_r  <= 3'd0;
            dq_r  <= 8'h00;
            oe_r  <= 1'b0;
            wp_r  <= 1'b0;
            rdd_r <= 8'h00;
            for (int i = 0; i < NREG; i++)
            begin
                mem_r[i] <= `QHP_REG_RESET;
            end
        end
        else
        begin
            s1_r  <= pins;
            s2_r  <= s1_r;
            act_r <= act_nxt;
            rdg_r <= rdg_nxt;
            ch_r  <= ch_nxt;
            ad_r  <= ad_nxt;
            dq_r  <= dq_nxt;
            oe_r  <= oe_nxt;
            wp_r  <= wp_nxt;
            rdd_r <= rdd_nxt;
            for (int i = 0; i < NREG; i++)
            begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end
    assign bus.data_d2h    = dq_r;
    assign bus.data_d2h_oe = oe_r;
    assign RD_DATA  = rdd_r;
    assign WR_PULSE = wp_r;
    assign WR_CHAN  = ch_r;
    assign WR_ADDR  = ad_r;
    assign WR_DATA  = dq_r;
endmodule : qhp_device

/* File: rtl/qhp_regs.svh */
`ifndef QHP_REGS_SVH
`define QHP_REGS_SVH
`define QHP_ADDR_W        3
`define QHP_DATA_W        8
`define QHP_NUM_CHAN      4
`define QHP_REG_RESET     8'h00
`define QHP_STROBE_CYC    4
`define QHP_SETUP_CYC     2
`define QHP_HOLD_CYC      2
`endif

/* File: rtl/qhp_pkg.sv */
package qhp_pkg;
    typedef enum logic [1:0] {
        QHP_IDLE   = 2'b00,
        QHP_SETUP  = 2'b01,
        QHP_STROBE = 2'b10,
        QHP_HOLD   = 2'b11
    } qhp_state_t;
    typedef logic [7:0] qhp_byte_t;
    typedef logic [1:0] qhp_chan_t;
endpackage : qhp_pkg

/* File: rtl/qhp_bus_if.sv */
interface qhp_bus_if;
    logic       bus_style;
    logic [2:0] reg_addr;
    logic [7:0] data_h2d;
    logic       data_h2d_oe;
    logic [7:0] data_d2h;
    logic       data_d2h_oe;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       chan0_select_n;
    logic       chan1_select_n;
    logic       chan2_select_n;
    logic       chan3_select_n;
    wire  [7:0] data_bus;
    assign data_bus = data_d2h_oe ? data_d2h : (data_h2d_oe ? data_h2d : 8'hff);
    modport dev
    (
        input  bus_style, reg_addr, data_bus, read_strobe_n, write_strobe_n,
        input  chan0_select_n, chan1_select_n, chan2_select_n, chan3_select_n,
        output data_d2h, data_d2h_oe
    );
    modport host
    (
        output bus_style, reg_addr, data_h2d, data_h2d_oe, read_strobe_n, write_strobe_n,
        output chan0_select_n, chan1_select_n, chan2_select_n, chan3_select_n,
        input  data_bus
    );
endinterface : qhp_bus_if

/* File: rtl/qhp_host.sv */
`include "qhp_regs.svh"
module qhp_host
(
    // Host bus
    qhp_bus_if.host           bus,
    // Clock and reset
    input  wire logic         CLK,
    input  wire logic         RSTN,
    // Command port
    input  wire logic         STYLE,
    input  wire logic         REQ,
    input  wire logic         REQ_WRITE,
    input  wire logic [1:0]   REQ_CHAN,
    input  wire logic [2:0]   REQ_ADDR,
    input  wire logic [7:0]   REQ_DATA,
    output logic              BUSY,
    output logic              DONE,
    output logic      [7:0]   RDATA
);
    qhp_pkg::qhp_state_t st_r, st_nxt;
    logic       wr_r, wr_nxt;
    logic [1:0] ch_r, ch_nxt;
    logic [2:0] ad_r, ad_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic       done_r, done_nxt;
    logic       sty_r;
    logic [7:0] db1_r, db2_r;
    always_comb
    begin
        st_nxt   = st_r;
        wr_nxt   = wr_r;
        ch_nxt   = ch_r;
        ad_nxt   = ad_r;
        wd_nxt   = wd_r;
        rd_nxt   = rd_r;
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        case (st_r)
            qhp_pkg::QHP_IDLE:
            begin
                if (REQ)
                begin
                    wr_nxt  = REQ_WRITE;
                    ch_nxt  = REQ_CHAN;
                    ad_nxt  = REQ_ADDR;
                    wd_nxt  = REQ_DATA;
                    cnt_nxt = 3'(`QHP_SETUP_CYC);
                    st_nxt  = qhp_pkg::QHP_SETUP;
                end
            end
            qhp_pkg::QHP_SETUP:
            begin
                cnt_nxt = cnt_r - 3'd1;
                if (cnt_r == 3'd1)
                begin
                    cnt_nxt = 3'(`QHP_STROBE_CYC);
                    st_nxt  = qhp_pkg::QHP_STROBE;
                end
            end
            qhp_pkg::QHP_STROBE:
            begin
                cnt_nxt = cnt_r - 3'd1;
                if (cnt_r == 3'd1)
                begin
                    cnt_nxt = 3'(`QHP_HOLD_CYC);
                    st_nxt  = qhp_pkg::QHP_HOLD;
                end
            end
            qhp_pkg::QHP_HOLD:
            begin
                cnt_nxt = cnt_r - 3'd1;
                if (cnt_r == 3'd1)
                begin
                    // Sync delay puts the strobe-release byte here
                    if (!wr_r)
                    begin
                        rd_nxt = db2_r; // see RQ4
                    end
                    done_nxt = 1'b1;
                    st_nxt   = qhp_pkg::QHP_IDLE;
                end
            end
            default:
            begin
                st_nxt = qhp_pkg::QHP_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st_r   <= qhp_pkg::QHP_IDLE;
            wr_r   <= 1'b0;
            ch_r   <= 2'd0;
            ad_r   <= 3'd0;
            wd_r   <= 8'h00;
            rd_r   <= 8'h00;
            cnt_r  <= 3'd0;
            done_r <= 1'b0;
            sty_r  <= 1'b1;
            db1_r  <= 8'h00;
            db2_r  <= 8'h00;
        end
        else
        begin
            st_r   <= st_nxt;
            wr_r   <= wr_nxt;
            ch_r   <= ch_nxt;
            ad_r   <= ad_nxt;
            wd_r   <= wd_nxt;
            rd_r   <= rd_nxt;
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
            sty_r  <= STYLE; // see RQ1
            db1_r  <= bus.data_bus;
            db2_r  <= db1_r;
        end
    end
    logic act;
    logic stb;
    assign act = (st_r != qhp_pkg::QHP_IDLE);
    assign stb = (st_r == qhp_pkg::QHP_STROBE);
    assign bus.bus_style   = sty_r;
    assign bus.reg_addr    = ad_r; // see RQ2
    assign bus.data_h2d    = wd_r;
    assign bus.data_h2d_oe = act && wr_r; // see RQ3
    // Strobe style: one select, strobes pulse
    // Direction style: CS0 strobe, CS1/CS2 channel, write strobe direction, rest high
    assign bus.read_strobe_n  = sty_r ? !(stb && !wr_r) : 1'b1; // see RQ7
    assign bus.write_strobe_n = sty_r ? !(stb && wr_r) : !wr_r; // see RQ8
    assign bus.chan0_select_n = sty_r ? !(stb && ch_r == 2'd0) : !stb; // see RQ9
    assign bus.chan1_select_n = sty_r ? !(stb && ch_r == 2'd1) : ch_r[0]; // see RQ10
    assign bus.chan2_select_n = sty_r ? !(stb && ch_r == 2'd2) : ch_r[1]; // see RQ10
    assign bus.chan3_select_n = sty_r ? !(stb && ch_r == 2'd3) : 1'b1; // see RQ11
    assign BUSY  = act;
    assign DONE  = done_r;
    assign RDATA = rd_r;
endmodule : qhp_host

/* File: test/qhp_bus_sva.sv */
module qhp_bus_sva
(
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RSTN,
    // Bus
    input wire logic       bus_style,
    input wire logic [2:0] reg_addr,
    input wire logic       data_h2d_oe,
    input wire logic       data_d2h_oe,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       chan0_select_n,
    input wire logic       chan1_select_n,
    input wire logic       chan2_select_n,
    input wire logic       chan3_select_n
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    sequence rd_begin;
        (bus_style && $fell(read_strobe_n)) || (!bus_style && $fell(chan0_select_n) && write_strobe_n);
    endsequence
    sequence rd_end;
        (bus_style && $rose(read_strobe_n)) || (!bus_style && $rose(chan0_select_n) && $past(write_strobe_n));
    endsequence
    a_read_drive_on: assert property (rd_begin |-> ##[2:4] data_d2h_oe)
        else $error("Read data not driven");
    a_read_drive_off: assert property (rd_end |-> ##[2:4] !data_d2h_oe)
        else $error("Read data not released");
    a_one_select: assert property (bus_style && !(read_strobe_n && write_strobe_n)
        |-> $countones({chan3_select_n, chan2_select_n, chan1_select_n, chan0_select_n}) == 3)
        else $error("Not exactly one select");
    a_dir_pins_tied: assert property (!bus_style |-> read_strobe_n && chan3_select_n)
        else $error("Unused pin not high");
    a_drive_exclusive: assert property (!(data_d2h_oe && data_h2d_oe))
        else $error("Both ends drive data");
    a_write_host_drives: assert property ((bus_style || !chan0_select_n) && !write_strobe_n
        |-> data_h2d_oe && !data_d2h_oe)
        else $error("Wrong driver during write");
    a_wstrobe_width: assert property (bus_style && $fell(write_strobe_n)
        |-> (!write_strobe_n) [*4] ##1 write_strobe_n)
        else $error("Write strobe width wrong");
    a_addr_stable: assert property ($fell(chan0_select_n) |-> ##1 ($stable(reg_addr)
        && $stable(write_strobe_n) && $stable({chan2_select_n, chan1_select_n})) [*3])
        else $error("Address moved in access");
    a_dir_frame: assert property (!bus_style && $fell(chan0_select_n)
        |-> (!chan0_select_n) [*4] ##1 chan0_select_n)
        else $error("Select frame width wrong");
endmodule : qhp_bus_sva

/* File: test/testbench.sv */
`include "qhp_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk, rstn, style, req, req_write, wr_pulse, busy, done, seen_ws;
    qhp_pkg::qhp_chan_t  req_chan, rd_chan, wr_chan;
    logic [2:0]          req_addr, rd_addr, wr_addr;
    qhp_pkg::qhp_byte_t  req_data, rd_data, wr_data, rdata;
    qhp_pkg::qhp_byte_t  mem [4][8];
    logic [3:0]          seen_sel;
    logic [12:0]         wr_seen;
    int                  miscompares, n_checks, wr_cnt;
    integer              seed;
    logic [31:0]         r;
    qhp_bus_if bus_if ();
    qhp_device i_qhp_device (.bus(bus_if), .CLK(clk), .RSTN(rstn), .RD_CHAN(rd_chan), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .WR_PULSE(wr_pulse), .WR_CHAN(wr_chan), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
    qhp_host i_qhp_host (.bus(bus_if), .CLK(clk), .RSTN(rstn), .STYLE(style), .REQ(req), .REQ_WRITE(req_write),
        .REQ_CHAN(req_chan), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BUSY(busy), .DONE(done), .RDATA(rdata));
    qhp_bus_sva i_qhp_bus_sva (.CLK(clk), .RSTN(rstn), .bus_style(bus_if.bus_style), .reg_addr(bus_if.reg_addr),
        .data_h2d_oe(bus_if.data_h2d_oe), .data_d2h_oe(bus_if.data_d2h_oe),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .chan0_select_n(bus_if.chan0_select_n), .chan1_select_n(bus_if.chan1_select_n),
        .chan2_select_n(bus_if.chan2_select_n), .chan3_select_n(bus_if.chan3_select_n));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Wire and commit monitor
    always @(posedge clk)
    begin
        if (wr_pulse === 1'b1)
        begin
            wr_seen = {wr_chan, wr_addr, wr_data};
            wr_cnt++;
        end
        if (bus_if.bus_style ? !(bus_if.read_strobe_n && bus_if.write_strobe_n) : !bus_if.chan0_select_n)
        begin
            seen_sel = {bus_if.chan3_select_n, bus_if.chan2_select_n, bus_if.chan1_select_n, bus_if.chan0_select_n};
            seen_ws = bus_if.write_strobe_n;
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [3:0] exp_sel(input logic s, input qhp_pkg::qhp_chan_t c);
        return s ? ~(4'h1 << c) : {1'b1, c, 1'b0};
    endfunction : exp_sel
    task automatic access(input logic s, input logic w, input qhp_pkg::qhp_chan_t c, input logic [2:0] a,
        input qhp_pkg::qhp_byte_t d);
        int n;
        int k;
        int nb;
        k = wr_cnt;
        seen_sel = 4'hx;
        seen_ws = 1'bx;
        style = s;
        req = 1'b1;
        req_write = w;
        req_chan = c;
        req_addr = a;
        req_data = d;
        n = 0;
        nb = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (busy === 1'b1)
                nb++;
        end
        while (done !== 1'b1 && n < 40);
        req = 1'b0;
        if (n >= 40)
        begin
            miscompares++;
            results();
        end
        check(16'(nb), 16'(`QHP_SETUP_CYC + `QHP_STROBE_CYC + `QHP_HOLD_CYC));
        check({15'h0, busy}, 16'h0);
        check({12'h0, seen_sel}, {12'h0, exp_sel(s, c)});
        check({15'h0, seen_ws}, {15'h0, !w});
        if (w)
        begin
            mem[c][a] = d;
            n = 0;
            while (wr_cnt == k && n < 10)
            begin
                @(negedge clk);
                n++;
            end
            if (wr_cnt == k)
            begin
                miscompares++;
                results();
            end
            check({3'h0, wr_seen}, {3'h0, c, a, d});
        end
        else
            check({8'h0, rdata}, {8'h0, mem[c][a]});
        rd_chan = c;
        rd_addr = a;
        repeat (2) @(negedge clk);
        check({8'h0, rd_data}, {8'h0, mem[c][a]});
    endtask : access
    initial
    begin
        seed = 32'h2d4044a3;
        {rstn, style, req, req_write, req_chan, req_addr, req_data, rd_chan, rd_addr} = '0;
        {miscompares, n_checks, wr_cnt} = '0;
        foreach (mem[i, j]) mem[i][j] = `QHP_REG_RESET;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        // Reset value, then every channel in both styles, back to back
        access(1'b1, 1'b0, 2'h3, 3'h7, 8'h00);
        for (int j = 0; j < 8; j++)
        begin
            access(j[2], 1'b1, j[1:0], 3'(j), 8'hff - 8'(j));
            access(!j[2], 1'b0, j[1:0], 3'(j), 8'h00);
        end
        for (int i = 0; i < 80; i++)
        begin
            r = $random(seed);
            access(r[0], r[1], r[3:2], r[6:4], r[15:8]);
        end
        results();
    end
endmodule : testbench
